/* rtl/fac_cfg.svh */
// constants for the flash access and program control block
// How it works
// - flash starts erased, nothing locked
// - one 128-byte page per program, within 3.5 ms
// - page or sector erase within 8 ms
// - few extra system cycles per operation
// - wait-state field direct; 1..4 by frequency
// - wait states only on non-sequential reads
// - prefetch ahead of current read address
// - reads from several modules: only module 3
// - one-module reads allow 4 parallel, else 1
// - never program or erase a module being read
// - at most 32 programs per page between erases
`ifndef FAC_CFG_SVH
`define FAC_CFG_SVH
// array geometry: address = {module, page, word}
`define FAC_ADDR_W 8
`define FAC_MOD_W 2
`define FAC_MODS 4
`define FAC_MOD_HI 7
`define FAC_MOD_LO 6
`define FAC_PAGE_BIT 5
`define FAC_WORD_W 5
`define FAC_PAGE_WORDS 32
`define FAC_PAGE_BYTES 128
`define FAC_WORDS 256
`define FAC_DATA_W 32
`define FAC_ERASED 32'hffffffff
// the only module that may work while several others are read
`define FAC_FREE_MOD 2'h3
`define FAC_MAX_PAR 4
// wait states
`define FAC_WS_W 3
`define FAC_WS_MAX 3'h4
`define FAC_WS_RST 3'h4
`define FAC_WS1_MHZ 8
`define FAC_WS2_MHZ 13
`define FAC_WS3_MHZ 17
// timing
`define FAC_CLK_MHZ 40
`define FAC_PROG_TIME_US 3500
`define FAC_ERASE_TIME_US 8000
`define FAC_PROG_CYCLES (`FAC_PROG_TIME_US * `FAC_CLK_MHZ)
`define FAC_ERASE_CYCLES (`FAC_ERASE_TIME_US * `FAC_CLK_MHZ)
`define FAC_OVH_CYCLES 4
`define FAC_TMR_W 20
`define FAC_READ_HOLD 8'h10
// program count limit per page before erase
`define FAC_DD_LIMIT 6'h20
`endif

/* rtl/fac_pkg.sv */
// types for both ends of the flash access and program control block; the read state type is used by the controller only
package fac_pkg;
    typedef enum logic [1:0] {FAC_OP_PROG, FAC_OP_ERASE_PAGE, FAC_OP_ERASE_SECTOR} fac_op_type;
    typedef enum logic {FAC_RD_IDLE, FAC_RD_WAIT} fac_rd_state_type;
endpackage : fac_pkg

/* rtl/fac_bus_if.sv */
// internal memory bus between the requesting side and the flash controller
`timescale 1ns/1ps
`include "fac_cfg.svh"
interface fac_bus_if;
    logic rd_req;
    logic [`FAC_ADDR_W-1:0] rd_addr;
    logic rd_ack;
    logic [`FAC_DATA_W-1:0] rd_data;
    logic [`FAC_WS_W-1:0] flash_wait_state_count;
    logic ld_req;
    logic [`FAC_WORD_W-1:0] ld_idx;
    logic [`FAC_DATA_W-1:0] ld_data;
    logic cmd_req;
    fac_pkg::fac_op_type cmd_op;
    logic [`FAC_MOD_W-1:0] cmd_mod;
    logic cmd_page;
    logic cmd_ack;
    logic cmd_err;
    logic [`FAC_MODS-1:0] mod_busy;
    modport device (
        input rd_req, rd_addr, flash_wait_state_count, ld_req, ld_idx, ld_data,
        input cmd_req, cmd_op, cmd_mod, cmd_page,
        output rd_ack, rd_data, cmd_ack, cmd_err, mod_busy
    );
    modport requester (
        output rd_req, rd_addr, flash_wait_state_count, ld_req, ld_idx, ld_data,
        output cmd_req, cmd_op, cmd_mod, cmd_page,
        input rd_ack, rd_data, cmd_ack, cmd_err, mod_busy
    );
endinterface : fac_bus_if

/* rtl/fac_flash_ctrl.sv */
// flash controller end: wait states, prefetch, page buffer, program and erase
`timescale 1ns/1ps
`include "fac_cfg.svh"
module fac_flash_ctrl #(
    parameter int unsigned PROG_CYCLES = `FAC_PROG_CYCLES,
    parameter int unsigned ERASE_CYCLES = `FAC_ERASE_CYCLES
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // bus to the requesting side
    fac_bus_if.device bus,
    // status
    output logic [`FAC_MODS-1:0] flash_busy_o,
    output logic refused_o
);
    ////////////////////////////////////////////////////////////////////////////
    // storage and state
    logic [`FAC_DATA_W-1:0] array_q [`FAC_WORDS];
    logic [`FAC_DATA_W-1:0] page_buf_q [`FAC_PAGE_WORDS];
    fac_pkg::fac_rd_state_type rd_state_q;
    logic [`FAC_ADDR_W-1:0] pf_addr_q;
    logic [`FAC_WS_W-1:0] pf_cnt_q;
    logic rd_ack_q;
    logic [`FAC_DATA_W-1:0] rd_data_q;
    logic cmd_ack_q;
    logic cmd_err_q;
    logic [`FAC_TMR_W-1:0] tmr_q [`FAC_MODS];
    logic [7:0] recent_q [`FAC_MODS];
    logic [`FAC_MODS-1:0] busy;
    logic [`FAC_MODS-1:0] reading;
    logic [`FAC_WS_W-1:0] ws_eff;
    logic [`FAC_MOD_W-1:0] rd_mod;
    logic rd_start;
    logic rd_done;
    logic cmd_new;
    logic cmd_ok;
    logic [2:0] n_reading;
    logic [2:0] n_busy;

    assign rd_mod = bus.rd_addr[`FAC_MOD_HI:`FAC_MOD_LO];
    // a request still high in the ack cycle is the old one, not a new one
    assign rd_start = bus.rd_req && !rd_ack_q && (rd_state_q == fac_pkg::FAC_RD_IDLE);
    assign cmd_new = bus.cmd_req && !cmd_ack_q && !cmd_err_q;

    ////////////////////////////////////////////////////////////////////////////
    // wait-state decode: field is the count itself; illegal zero runs at the safe maximum
    always_comb
    begin
        if (bus.flash_wait_state_count == 3'h0 || bus.flash_wait_state_count > `FAC_WS_MAX)
        begin
            ws_eff = `FAC_WS_MAX;
        end
        else
        begin
            ws_eff = bus.flash_wait_state_count;
        end
    end

    // a word is ready when the prefetch slot holds its address, its count ran out and its module is not busy
    assign rd_done = (rd_state_q == fac_pkg::FAC_RD_WAIT) && (pf_cnt_q == 3'h0)
        && (pf_addr_q == bus.rd_addr) && !busy[rd_mod];

    ////////////////////////////////////////////////////////////////////////////
    // read engine with one-word prefetch slot
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            rd_state_q <= fac_pkg::FAC_RD_IDLE;
            pf_addr_q <= 8'h00;
            pf_cnt_q <= `FAC_WS_RST;
            rd_ack_q <= 1'b0;
            rd_data_q <= 32'h00000000;
        end
        else
        begin
            rd_ack_q <= 1'b0;
            if (rd_done)
            begin
                rd_ack_q <= 1'b1;
                rd_data_q <= array_q[pf_addr_q];
                rd_state_q <= fac_pkg::FAC_RD_IDLE;
                pf_addr_q <= pf_addr_q + 8'h01;
                pf_cnt_q <= ws_eff;
            end
            else if (rd_start && bus.rd_addr != pf_addr_q)
            begin
                // jump: the whole wait-state count is paid
                rd_state_q <= fac_pkg::FAC_RD_WAIT;
                pf_addr_q <= bus.rd_addr;
                pf_cnt_q <= ws_eff;
            end
            else
            begin
                // sequential hit only waits for what remains of the prefetch
                if (rd_start)
                begin
                    rd_state_q <= fac_pkg::FAC_RD_WAIT;
                end
                if (pf_cnt_q != 3'h0)
                begin
                    pf_cnt_q <= pf_cnt_q - 3'h1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-module busy timers and recent-read windows
    genvar m;
    generate
        for (m = 0; m < `FAC_MODS; m++)
        begin : g_mod
            assign busy[m] = (tmr_q[m] != 20'h00000);
            assign reading[m] = (recent_q[m] != 8'h00)
                || (rd_state_q == fac_pkg::FAC_RD_WAIT && rd_mod == m);
            // the window keeps a module marked as read between close fetches
            always_ff @(posedge clk_sys_i)
            begin
                if (rst_i)
                begin
                    recent_q[m] <= 8'h00;
                end
                else if (rd_done && rd_mod == m)
                begin
                    recent_q[m] <= `FAC_READ_HOLD;
                end
                else if (recent_q[m] != 8'h00)
                begin
                    recent_q[m] <= recent_q[m] - 8'h01;
                end
            end
            // time of the operation plus the sequencer's own cycles
            always_ff @(posedge clk_sys_i)
            begin
                if (rst_i)
                begin
                    tmr_q[m] <= 20'h00000;
                end
                else if (cmd_ok && bus.cmd_mod == m)
                begin
                    if (bus.cmd_op == fac_pkg::FAC_OP_PROG)
                    begin
                        tmr_q[m] <= `FAC_TMR_W'(PROG_CYCLES + `FAC_OVH_CYCLES);
                    end
                    else
                    begin
                        tmr_q[m] <= `FAC_TMR_W'(ERASE_CYCLES + `FAC_OVH_CYCLES);
                    end
                end
                else if (busy[m])
                begin
                    tmr_q[m] <= tmr_q[m] - 20'h00001;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // admission of program and erase requests
    always_comb
    begin
        n_reading = 3'h0;
        n_busy = 3'h0;
        for (int i = 0; i < `FAC_MODS; i++)
        begin
            n_reading = n_reading + {2'h0, reading[i]};
            n_busy = n_busy + {2'h0, busy[i]};
        end
    end

    always_comb
    begin
        cmd_ok = 1'b0;
        if (cmd_new && !busy[bus.cmd_mod] && !reading[bus.cmd_mod])
        begin
            if (n_reading > 3'h1)
            begin
                cmd_ok = (bus.cmd_mod == `FAC_FREE_MOD) && (n_busy == 3'h0);
            end
            else
            begin
                cmd_ok = (n_busy < 3'(`FAC_MAX_PAR));
            end
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            cmd_ack_q <= 1'b0;
            cmd_err_q <= 1'b0;
        end
        else
        begin
            cmd_ack_q <= cmd_ok;
            cmd_err_q <= cmd_new && !cmd_ok;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // page buffer, loaded one word at a time
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < `FAC_PAGE_WORDS; i++)
            begin
                page_buf_q[i] <= `FAC_ERASED;
            end
        end
        else if (bus.ld_req)
        begin
            page_buf_q[bus.ld_idx] <= bus.ld_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // array: programming only clears bits, erase sets them back
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < `FAC_WORDS; i++)
            begin
                array_q[i] <= `FAC_ERASED;
            end
        end
        else if (cmd_ok)
        begin
            for (int i = 0; i < `FAC_WORDS; i++)
            begin
                if (i[`FAC_MOD_HI:`FAC_MOD_LO] == bus.cmd_mod)
                begin
                    if (bus.cmd_op == fac_pkg::FAC_OP_ERASE_SECTOR)
                    begin
                        array_q[i] <= `FAC_ERASED;
                    end
                    else if (i[`FAC_PAGE_BIT] == bus.cmd_page)
                    begin
                        if (bus.cmd_op == fac_pkg::FAC_OP_PROG)
                        begin
                            array_q[i] <= array_q[i] & page_buf_q[i[`FAC_WORD_W-1:0]];
                        end
                        else
                        begin
                            array_q[i] <= `FAC_ERASED;
                        end
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all registered except mod_busy, which is decoded from the timers
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            flash_busy_o <= 4'h0;
            refused_o <= 1'b0;
        end
        else
        begin
            flash_busy_o <= busy;
            refused_o <= cmd_new && !cmd_ok;
        end
    end

    assign bus.rd_ack = rd_ack_q;
    assign bus.rd_data = rd_data_q;
    assign bus.cmd_ack = cmd_ack_q;
    assign bus.cmd_err = cmd_err_q;
    assign bus.mod_busy = busy;
endmodule : fac_flash_ctrl

/* rtl/fac_requester.sv */
// requesting end: picks wait states, holds bus requests, polices program counts
`timescale 1ns/1ps
`include "fac_cfg.svh"
module fac_requester (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // configuration
    input wire logic [7:0] fsys_mhz_i,
    // cpu reads
    input wire logic cpu_rd_req_i,
    input wire logic [`FAC_ADDR_W-1:0] cpu_rd_addr_i,
    output logic cpu_rd_ack_o,
    output logic [`FAC_DATA_W-1:0] cpu_rd_data_o,
    // page buffer loads
    input wire logic cpu_ld_req_i,
    input wire logic [`FAC_WORD_W-1:0] cpu_ld_idx_i,
    input wire logic [`FAC_DATA_W-1:0] cpu_ld_data_i,
    // program and erase commands
    input wire logic cpu_cmd_req_i,
    input wire fac_pkg::fac_op_type cpu_cmd_op_i,
    input wire logic [`FAC_MOD_W-1:0] cpu_cmd_mod_i,
    input wire logic cpu_cmd_page_i,
    output logic cpu_cmd_done_o,
    output logic cpu_cmd_err_o,
    // bus to the flash controller
    fac_bus_if.requester bus
);
    logic [`FAC_WS_W-1:0] ws_q;
    logic rd_req_q;
    logic [`FAC_ADDR_W-1:0] rd_addr_q;
    logic ld_req_q;
    logic [`FAC_WORD_W-1:0] ld_idx_q;
    logic [`FAC_DATA_W-1:0] ld_data_q;
    logic cmd_req_q;
    fac_pkg::fac_op_type cmd_op_q;
    logic [`FAC_MOD_W-1:0] cmd_mod_q;
    logic cmd_page_q;
    logic [5:0] prog_cnt_q [2*`FAC_MODS];
    logic [2:0] sel;
    logic local_bad;

    ////////////////////////////////////////////////////////////////////////////
    // fastest legal access count for the running frequency; zero is never chosen
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            ws_q <= `FAC_WS_RST;
        else if (fsys_mhz_i <= 8'(`FAC_WS1_MHZ))
            ws_q <= 3'h1;
        else if (fsys_mhz_i <= 8'(`FAC_WS2_MHZ))
            ws_q <= 3'h2;
        else if (fsys_mhz_i <= 8'(`FAC_WS3_MHZ))
            ws_q <= 3'h3;
        else
            ws_q <= `FAC_WS_MAX;
    end

    ////////////////////////////////////////////////////////////////////////////
    // read request held until the controller answers
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            rd_req_q <= 1'b0;
            rd_addr_q <= 8'h00;
            cpu_rd_ack_o <= 1'b0;
            cpu_rd_data_o <= 32'h00000000;
            ld_req_q <= 1'b0;
            ld_idx_q <= 5'h00;
            ld_data_q <= 32'h00000000;
        end
        else
        begin
            cpu_rd_ack_o <= bus.rd_ack;
            ld_req_q <= cpu_ld_req_i;
            ld_idx_q <= cpu_ld_idx_i;
            ld_data_q <= cpu_ld_data_i;
            if (bus.rd_ack)
            begin
                rd_req_q <= 1'b0;
                cpu_rd_data_o <= bus.rd_data;
            end
            else if (cpu_rd_req_i && !rd_req_q)
            begin
                rd_req_q <= 1'b1;
                rd_addr_q <= cpu_rd_addr_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // local checks: too many programs on a page, or a module we are reading
    assign sel = {cpu_cmd_mod_i, cpu_cmd_page_i};
    assign local_bad = (cpu_cmd_op_i == fac_pkg::FAC_OP_PROG && prog_cnt_q[sel] >= `FAC_DD_LIMIT)
        || (rd_req_q && rd_addr_q[`FAC_MOD_HI:`FAC_MOD_LO] == cpu_cmd_mod_i);

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            cmd_req_q <= 1'b0;
            cmd_op_q <= fac_pkg::FAC_OP_PROG;
            cmd_mod_q <= 2'h0;
            cmd_page_q <= 1'b0;
            cpu_cmd_done_o <= 1'b0;
            cpu_cmd_err_o <= 1'b0;
        end
        else
        begin
            cpu_cmd_done_o <= bus.cmd_ack;
            cpu_cmd_err_o <= bus.cmd_err || (cpu_cmd_req_i && !cmd_req_q && local_bad);
            if (bus.cmd_ack || bus.cmd_err)
            begin
                cmd_req_q <= 1'b0;
            end
            else if (cpu_cmd_req_i && !cmd_req_q && !local_bad)
            begin
                cmd_req_q <= 1'b1;
                cmd_op_q <= cpu_cmd_op_i;
                cmd_mod_q <= cpu_cmd_mod_i;
                cmd_page_q <= cpu_cmd_page_i;
            end
        end
    end

    // programs since erase, per page; erase of page or whole module clears
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < 2*`FAC_MODS; i++)
                prog_cnt_q[i] <= 6'h00;
        end
        else if (bus.cmd_ack)
        begin
            for (int i = 0; i < 2*`FAC_MODS; i++)
            begin
                if (i[2:1] == cmd_mod_q)
                begin
                    if (cmd_op_q == fac_pkg::FAC_OP_ERASE_SECTOR)
                        prog_cnt_q[i] <= 6'h00;
                    else if (i[0] == cmd_page_q && cmd_op_q == fac_pkg::FAC_OP_ERASE_PAGE)
                        prog_cnt_q[i] <= 6'h00;
                    else if (i[0] == cmd_page_q)
                        prog_cnt_q[i] <= prog_cnt_q[i] + 6'h01;
                end
            end
        end
    end

    assign bus.flash_wait_state_count = ws_q;
    assign bus.rd_req = rd_req_q;
    assign bus.rd_addr = rd_addr_q;
    assign bus.ld_req = ld_req_q;
    assign bus.ld_idx = ld_idx_q;
    assign bus.ld_data = ld_data_q;
    assign bus.cmd_req = cmd_req_q;
    assign bus.cmd_op = cmd_op_q;
    assign bus.cmd_mod = cmd_mod_q;
    assign bus.cmd_page = cmd_page_q;
endmodule : fac_requester

/* test/fac_asserts.sv */
// bus checker between the requester and the flash controller
`timescale 1ns/1ps
`include "fac_cfg.svh"
module fac_asserts #(
    parameter int unsigned PROG_CYCLES = 20,
    parameter int unsigned ERASE_CYCLES = 40
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // read side
    input wire logic rd_req,
    input wire logic [`FAC_ADDR_W-1:0] rd_addr,
    input wire logic rd_ack,
    input wire logic [`FAC_DATA_W-1:0] rd_data,
    input wire logic [`FAC_WS_W-1:0] flash_wait_state_count,
    // command side
    input wire logic cmd_req,
    input wire fac_pkg::fac_op_type cmd_op,
    input wire logic [`FAC_MOD_W-1:0] cmd_mod,
    input wire logic cmd_ack,
    input wire logic cmd_err,
    input wire logic [`FAC_MODS-1:0] mod_busy
);
    // busy spans include the accept cycle plus the fixed overhead
    localparam int PROG_HOLD = PROG_CYCLES + 3;
    localparam int ERASE_HOLD = ERASE_CYCLES + 3;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////////////
    // read path
    a_ws_legal_range: assert property (flash_wait_state_count inside {[3'h1:3'h4]})
        else $error("wait-state field outside one to four");
    a_rd_ack_single: assert property (rd_ack |=> !rd_ack)
        else $error("read ack longer than one cycle");
    a_rd_data_hold: assert property (!rd_ack |-> $stable(rd_data))
        else $error("read data moved without ack");
    ////////////////////////////////////////////////////////////////////////////////
    // command path
    a_cmd_answer_next: assert property (cmd_req && !cmd_ack && !cmd_err |=> cmd_ack || cmd_err)
        else $error("command not answered next cycle");
    a_ack_err_apart: assert property (!(cmd_ack && cmd_err))
        else $error("command both accepted and refused");
    a_no_work_read: assert property (cmd_ack |-> !($past(rd_req) && ($past(rd_addr) >> 6) == {6'h0, cmd_mod}))
        else $error("command accepted on a module under read");
    a_busy_refused: assert property (cmd_req && !cmd_ack && !cmd_err && mod_busy[cmd_mod] |=> cmd_err)
        else $error("command on busy module not refused");
    a_prog_busy_len: assert property (cmd_ack && cmd_mod == 2'h3 && cmd_op == fac_pkg::FAC_OP_PROG |-> ##PROG_HOLD mod_busy[3] ##1 !mod_busy[3])
        else $error("program busy span wrong");
    a_erase_busy_len: assert property (cmd_ack && cmd_mod == 2'h3 && cmd_op != fac_pkg::FAC_OP_PROG |-> ##ERASE_HOLD mod_busy[3] ##1 !mod_busy[3])
        else $error("erase busy span wrong");
    // main scenarios reached
    c_rd: cover property (rd_ack);
    c_err: cover property (cmd_err);
    c_sector: cover property (cmd_ack && cmd_op == fac_pkg::FAC_OP_ERASE_SECTOR);
    c_three: cover property ($countones(mod_busy) == 3);
endmodule : fac_asserts

/* test/flash_access_and_program_control_tb.sv */
// self-checking bench joining the requester and the flash controller
`timescale 1ns/1ps
`include "fac_cfg.svh"
module flash_access_and_program_control_tb;
    // short program and erase spans keep the run brief
    localparam int unsigned PC = 20;
    localparam int unsigned EC = 40;
    localparam logic [31:0] ERASED = `FAC_ERASED;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] fsys = 8'h28;
    logic rd_req = 1'b0, ld_req = 1'b0, cmd_req = 1'b0, cmd_page = 1'b0;
    logic [7:0] rd_addr = 8'h00;
    logic [4:0] ld_idx = 5'h00;
    logic [31:0] ld_data = 32'h0;
    fac_pkg::fac_op_type cmd_op = fac_pkg::FAC_OP_PROG;
    logic [1:0] cmd_mod = 2'h0;
    logic rd_ack, done, err, refused;
    logic [31:0] rd_data;
    logic [3:0] busy;
    int mismatches = 0;
    int checks = 0;
    int base, lat;
    ////////////////////////////////////////////////////////////////////////////////
    // clock and the two ends
    always #12.5 clk_sys_i = ~clk_sys_i;
    fac_bus_if i_fac_bus_if ();
    fac_flash_ctrl #(.PROG_CYCLES(PC), .ERASE_CYCLES(EC)) i_fac_flash_ctrl (
        .clk_sys_i, .rst_i, .bus(i_fac_bus_if.device), .flash_busy_o(busy), .refused_o(refused));
    fac_requester i_fac_requester (
        .clk_sys_i, .rst_i, .fsys_mhz_i(fsys), .cpu_rd_req_i(rd_req), .cpu_rd_addr_i(rd_addr),
        .cpu_rd_ack_o(rd_ack), .cpu_rd_data_o(rd_data), .cpu_ld_req_i(ld_req),
        .cpu_ld_idx_i(ld_idx), .cpu_ld_data_i(ld_data), .cpu_cmd_req_i(cmd_req),
        .cpu_cmd_op_i(cmd_op), .cpu_cmd_mod_i(cmd_mod), .cpu_cmd_page_i(cmd_page),
        .cpu_cmd_done_o(done), .cpu_cmd_err_o(err), .bus(i_fac_bus_if.requester));
    fac_asserts #(.PROG_CYCLES(PC), .ERASE_CYCLES(EC)) i_fac_asserts (
        .clk_sys_i, .rst_i, .rd_req(i_fac_bus_if.rd_req), .rd_addr(i_fac_bus_if.rd_addr),
        .rd_ack(i_fac_bus_if.rd_ack), .rd_data(i_fac_bus_if.rd_data),
        .flash_wait_state_count(i_fac_bus_if.flash_wait_state_count),
        .cmd_req(i_fac_bus_if.cmd_req), .cmd_op(i_fac_bus_if.cmd_op),
        .cmd_mod(i_fac_bus_if.cmd_mod), .cmd_ack(i_fac_bus_if.cmd_ack),
        .cmd_err(i_fac_bus_if.cmd_err), .mod_busy(i_fac_bus_if.mod_busy));
    ////////////////////////////////////////////////////////////////////////////////
    // shared helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic results;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : results
    // one read; lat counts edges from the dropped request to the ack
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys_i);
        rd_req <= 1'b1;
        rd_addr <= a;
        @(posedge clk_sys_i);
        rd_req <= 1'b0;
        lat = 1;
        #1;
        while (rd_ack !== 1'b1 && lat < 60)
        begin
            @(posedge clk_sys_i);
            #1;
            lat++;
        end
        chk({31'h0, rd_ack}, 32'h1);
        chk(rd_data, exp);
    endtask : rd
    // fills all 32 buffer words, one a cycle
    task automatic ld_page(input logic [31:0] seed);
        for (int i = 0; i < 32; i++)
        begin
            @(posedge clk_sys_i);
            ld_req <= 1'b1;
            ld_idx <= 5'(i);
            ld_data <= seed + 32'(i);
        end
        @(posedge clk_sys_i);
        ld_req <= 1'b0;
    endtask : ld_page
    task automatic cmd(input fac_pkg::fac_op_type op, input logic [1:0] m, input logic p,
                       input logic ok);
        int n;
        logic seen;
        seen = 1'b0;
        @(posedge clk_sys_i);
        cmd_req <= 1'b1;
        cmd_op <= op;
        cmd_mod <= m;
        cmd_page <= p;
        @(posedge clk_sys_i);
        cmd_req <= 1'b0;
        n = 0;
        #1;
        while (done !== 1'b1 && err !== 1'b1 && n < 20)
        begin
            @(posedge clk_sys_i);
            #1;
            n++;
            seen = seen | refused;
        end
        chk({30'h0, done, err}, {30'h0, ok, !ok});
        // a refusal made by the controller shows on refused_o; local ones answer at once
        if (n > 0)
            chk({31'h0, seen}, {31'h0, !ok});
        if (ok)
            chk({31'h0, busy[m]}, 32'h1);
    endtask : cmd
    // waits out busy modules and the recent-read window
    task automatic idle;
        int n;
        n = 0;
        while (busy !== 4'h0 && n < 300)
        begin
            @(posedge clk_sys_i);
            n++;
        end
        chk({28'h0, busy}, 32'h0);
        repeat (20) @(posedge clk_sys_i);
    endtask : idle
    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_waits;
        logic [7:0] f [5] = '{8'h08, 8'h09, 8'h0d, 8'h11, 8'h28};
        logic [2:0] w [5] = '{3'h1, 3'h2, 3'h2, 3'h3, 3'h4};
        for (int i = 0; i < 5; i++)
        begin
            @(posedge clk_sys_i);
            fsys <= f[i];
            repeat (4) @(posedge clk_sys_i);
            chk({29'h0, i_fac_bus_if.flash_wait_state_count}, {29'h0, w[i]});
            rd(8'h04 + 8'(3 * i), ERASED);
            if (i == 0)
                base = lat;
            chk(32'(lat), 32'(base) + 32'(w[i]) - 32'h1);
        end
    endtask : t_waits
    // prefetched next word comes without the wait states
    task automatic t_seq;
        repeat (10) @(posedge clk_sys_i);
        rd(8'h11, ERASED);
        chk(32'(lat), 32'(base) - 32'h1);
    endtask : t_seq
    task automatic t_prog;
        ld_page(32'ha5a50000);
        cmd(fac_pkg::FAC_OP_PROG, 2'h3, 1'b0, 1'b1);
        cmd(fac_pkg::FAC_OP_PROG, 2'h3, 1'b1, 1'b0);
        idle();
        rd(8'hc5, 32'ha5a50005);
        idle();
        cmd(fac_pkg::FAC_OP_ERASE_PAGE, 2'h3, 1'b0, 1'b1);
        idle();
        rd(8'hc5, ERASED);
        // the module just read stays marked as read for a short window
        idle();
        cmd(fac_pkg::FAC_OP_PROG, 2'h3, 1'b1, 1'b1);
        idle();
        cmd(fac_pkg::FAC_OP_ERASE_SECTOR, 2'h3, 1'b0, 1'b1);
        idle();
        rd(8'he5, ERASED);
    endtask : t_prog
    task automatic t_parallel;
        idle();
        rd(8'h05, ERASED);
        cmd(fac_pkg::FAC_OP_PROG, 2'h0, 1'b0, 1'b0);
        cmd(fac_pkg::FAC_OP_PROG, 2'h1, 1'b0, 1'b1);
        cmd(fac_pkg::FAC_OP_PROG, 2'h2, 1'b0, 1'b1);
        cmd(fac_pkg::FAC_OP_PROG, 2'h3, 1'b0, 1'b1);
        idle();
        rd(8'h08, ERASED);
        rd(8'h45, 32'ha5a50005);
        cmd(fac_pkg::FAC_OP_PROG, 2'h2, 1'b1, 1'b0);
        cmd(fac_pkg::FAC_OP_PROG, 2'h3, 1'b1, 1'b1);
    endtask : t_parallel
    // the 33rd program on a page without erase is held back
    task automatic t_dd;
        idle();
        for (int i = 0; i < 32; i++)
        begin
            cmd(fac_pkg::FAC_OP_PROG, 2'h2, 1'b1, 1'b1);
            idle();
        end
        cmd(fac_pkg::FAC_OP_PROG, 2'h2, 1'b1, 1'b0);
        cmd(fac_pkg::FAC_OP_ERASE_PAGE, 2'h2, 1'b1, 1'b1);
        idle();
        cmd(fac_pkg::FAC_OP_PROG, 2'h2, 1'b1, 1'b1);
    endtask : t_dd
    ////////////////////////////////////////////////////////////////////////////////
    // main sequence and watchdog
    initial
    begin
        repeat (5) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        t_waits();
        t_seq();
        t_prog();
        t_parallel();
        t_dd();
        idle();
        results();
    end
    initial
    begin
        repeat (20000) @(posedge clk_sys_i);
        mismatches++;
        results();
    end
endmodule : flash_access_and_program_control_tb
